// [src/dsse_map.vh]
/*
  constants for the drive state and status encoder: register offsets,
  status word bit positions, state codes and reset values.
  assumes inclusion by bare name from the design files of this block.
*/
`ifndef DSSE_MAP_VH
`define DSSE_MAP_VH

// register offsets (word addresses on the plain port)
`define DSSE_ADDR_W 16
`define DSSE_OFS_STATE_WORD 16'h6041
`define DSSE_OFS_CTRL 16'h0000
`define DSSE_OFS_DECEL 16'h0001
`define DSSE_OFS_IRQ_STAT 16'h0002
`define DSSE_OFS_IRQ_MASK 16'h0003
`define DSSE_OFS_SPEED 16'h0004

// status word bits
`define DSSE_SW_RDY 0
`define DSSE_SW_SWON 1
`define DSSE_SW_OPEN 2
`define DSSE_SW_FAULT 3
`define DSSE_SW_DCBUS 4
`define DSSE_SW_QSTOP 5
`define DSSE_SW_INHIB 6
`define DSSE_SW_WARN 7

// control register bits
`define DSSE_CTRL_BRAKE_MAN 0
`define DSSE_CTRL_CMD_ENOP 1
`define DSSE_CTRL_CMD_RSTF 2
`define DSSE_CTRL_CMD_QSTOP 3

// interrupt status bits
`define DSSE_IRQ_W 4
`define DSSE_IRQ_STATE 0
`define DSSE_IRQ_MINOR 1
`define DSSE_IRQ_SERIOUS 2
`define DSSE_IRQ_REFUSED 3

// state codes, one hot
`define DSSE_ST_W 5
`define DSSE_ST_IDLE 5'h01
`define DSSE_ST_RUN 5'h02
`define DSSE_ST_QSTOP 5'h04
`define DSSE_ST_FREACT 5'h08
`define DSSE_ST_TROUBLE 5'h10

// reset values and widths
`define DSSE_DECEL_RST 16'h0100
`define DSSE_SPEED_W 16

`endif

// [src/dsse_sync2.v]
/*
  two flip-flop synchroniser for a single level.
  assumes the input is asynchronous to mclk_in.
*/
`timescale 1ns/10ps
module dsse_sync2
(
  input wire mclk_in,
  input wire sys_rst_in,
  input wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg sync_q;

  // first stage is read only by the second stage
  always @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// [src/dsse_ramp.v]
/*
  speed ramp: in stop mode it brings speed to zero at the given
  deceleration step per cycle, otherwise it follows the setpoint.
  assumes all inputs are on mclk_in.
*/
`timescale 1ns/10ps
`include "dsse_map.vh"
module dsse_ramp
(
  input wire mclk_in,
  input wire sys_rst_in,
  input wire stop_in,
  input wire [`DSSE_SPEED_W-1:0] setpoint_in,
  input wire [`DSSE_SPEED_W-1:0] decel_in,
  output wire [`DSSE_SPEED_W-1:0] speed_out,
  output wire standstill_out
);
  reg [`DSSE_SPEED_W-1:0] speed_q;
  reg [`DSSE_SPEED_W-1:0] speed_d;

  // stop mode ignores the setpoint and decelerates
  always @*
  begin
    speed_d = speed_q;
    if (stop_in)
    begin
      if (speed_q > decel_in)
        speed_d = speed_q - decel_in;
      else
        speed_d = {`DSSE_SPEED_W{1'b0}};
    end
    else
      speed_d = setpoint_in;
  end

  always @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      speed_q <= {`DSSE_SPEED_W{1'b0}};
    else
      speed_q <= speed_d;
  end

  assign speed_out = speed_q;
  assign standstill_out = (speed_q == {`DSSE_SPEED_W{1'b0}});
endmodule

// [src/dsse_top.v]
/*
  drive state machine with status word encoder for the run, quick stop,
  fault reaction and trouble states, plus brake, pulse inhibit and
  parameter write gating. registers reached over a plain port.
  assumes fault pins are asynchronous and a master drives the port.
*/
// Strobed register access was decided locally.
`timescale 1ns/10ps
`include "dsse_map.vh"
module dsse_top
(
  input wire mclk_in,
  input wire sys_rst_in,
  input wire [`DSSE_ADDR_W-1:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [15:0] reg_rdata_out,
  input wire minor_fault_in,
  input wire serious_fault_in,
  input wire fault_cause_in,
  input wire dcbus_ready_in,
  input wire warning_in,
  input wire switch_on_in,
  input wire [`DSSE_SPEED_W-1:0] setpoint_in,
  input wire param_wr_in,
  input wire param_needs_off_in,
  output wire param_accept_out,
  output wire param_refuse_out,
  output wire brake_open_out,
  output wire pulse_inhibit_out,
  output wire ctrl_loop_on_out,
  output wire [`DSSE_SPEED_W-1:0] speed_out,
  output wire irq_out
);
  // state codes
  localparam ST_IDLE = `DSSE_ST_IDLE;
  localparam ST_RUN = `DSSE_ST_RUN;
  localparam ST_QSTOP = `DSSE_ST_QSTOP;
  localparam ST_FREACT = `DSSE_ST_FREACT;
  localparam ST_TROUBLE = `DSSE_ST_TROUBLE;

  wire minor_s;
  wire serious_s;
  wire cause_s;
  wire dcbus_s;
  wire warn_s;
  wire swon_s;
  wire standstill;
  wire [`DSSE_SPEED_W-1:0] speed;

  reg [`DSSE_ST_W-1:0] state_q;
  reg [`DSSE_ST_W-1:0] state_d;
  reg [15:0] sw_q;
  reg [15:0] sw_d;
  reg brake_man_q;
  reg qstop_req_q;
  reg [15:0] decel_q;
  reg [`DSSE_IRQ_W-1:0] irq_stat_q;
  reg [`DSSE_IRQ_W-1:0] irq_mask_q;
  reg [15:0] rdata_q;
  reg pulse_inh_q;
  reg brake_open_q;

  // the six level pins cross into mclk_in before any logic looks at them
  dsse_sync2 u_sync_minor
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(minor_fault_in),
    .sync_out(minor_s)
  );
  dsse_sync2 u_sync_serious
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(serious_fault_in),
    .sync_out(serious_s)
  );
  dsse_sync2 u_sync_cause
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(fault_cause_in),
    .sync_out(cause_s)
  );
  dsse_sync2 u_sync_dcbus
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(dcbus_ready_in),
    .sync_out(dcbus_s)
  );
  dsse_sync2 u_sync_warn
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(warning_in),
    .sync_out(warn_s)
  );
  dsse_sync2 u_sync_swon
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(switch_on_in),
    .sync_out(swon_s)
  );

  // fault reaction and quick stop both ramp to standstill
  dsse_ramp u_ramp
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .stop_in(state_q != ST_RUN),
    .setpoint_in(setpoint_in),
    .decel_in(decel_q),
    .speed_out(speed),
    .standstill_out(standstill)
  );

  // command strobes: one cycle writes to the control register
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `DSSE_OFS_CTRL);
  wire cmd_enop = wr_ctrl && reg_wdata_in[`DSSE_CTRL_CMD_ENOP];
  wire cmd_rstf = wr_ctrl && reg_wdata_in[`DSSE_CTRL_CMD_RSTF];
  wire cmd_qstop = wr_ctrl && reg_wdata_in[`DSSE_CTRL_CMD_QSTOP];

  // status pattern for a state; x bits take their live sources
  function [15:0] sw_pattern;
    input [`DSSE_ST_W-1:0] st;
    input dcb;
    input wrn;
    input qs_keep;
    begin
      sw_pattern = 16'h0000; // reserved bits 15..8 read zero
      sw_pattern[`DSSE_SW_DCBUS] = dcb;
      sw_pattern[`DSSE_SW_WARN] = wrn;
      case (st)
        ST_RUN:
        begin
          sw_pattern[2:0] = 3'h7;
          sw_pattern[`DSSE_SW_QSTOP] = 1'b1;
        end
        ST_QSTOP:
        begin
          sw_pattern[2:0] = 3'h7; // bit 5 low, quick stop in force
        end
        ST_FREACT:
        begin
          sw_pattern[3:0] = 4'hf;
          sw_pattern[`DSSE_SW_QSTOP] = qs_keep; // held at last value
        end
        ST_TROUBLE:
        begin
          sw_pattern[`DSSE_SW_FAULT] = 1'b1;
          sw_pattern[`DSSE_SW_QSTOP] = qs_keep;
        end
        default:
        begin
          sw_pattern[`DSSE_SW_INHIB] = 1'b1;
          sw_pattern[`DSSE_SW_QSTOP] = 1'b1;
        end
      endcase
    end
  endfunction

  // next state; faults are checked first so they override commands
  always @*
  begin
    state_d = state_q;
    if (serious_s)
      state_d = ST_TROUBLE;
    else if (minor_s && state_q != ST_TROUBLE && state_q != ST_FREACT)
      state_d = ST_FREACT;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (swon_s && cmd_enop)
            state_d = ST_RUN;
        ST_RUN:
          if (cmd_qstop || qstop_req_q)
            state_d = ST_QSTOP;
        ST_QSTOP:
          if (cmd_enop)
            state_d = ST_RUN;
        ST_FREACT:
          if (standstill)
            state_d = ST_TROUBLE; // no master command needed
        ST_TROUBLE:
          if (cmd_rstf && !cause_s)
            state_d = ST_IDLE; // other commands ignored here
        default:
          state_d = ST_IDLE;
      endcase
    end
  end

  // status word follows the next state, so both change together
  always @*
  begin
    sw_d = sw_pattern(state_d, dcbus_s, warn_s, sw_q[`DSSE_SW_QSTOP]);
  end

  // state and status word registered side by side
  always @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= ST_IDLE;
      sw_q <= 16'h0060;
    end
    else
    begin
      state_q <= state_d;
      sw_q <= sw_d;
    end
  end

  // brake setting as it stands after this edge, so a command write that
  // also selects manual mode never opens the brake for one cycle
  wire brake_man_d = wr_ctrl ? reg_wdata_in[`DSSE_CTRL_BRAKE_MAN] :
                     brake_man_q;

  // power stage and brake outputs, registered with the state
  always @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pulse_inh_q <= 1'b1;
      brake_open_q <= 1'b0;
    end
    else
    begin
      pulse_inh_q <= !(state_d == ST_RUN || state_d == ST_QSTOP ||
                       state_d == ST_FREACT);
      // open only in run with automatic brake handling
      brake_open_q <= (state_d == ST_RUN) && !brake_man_d;
      // quick stop, fault reaction, trouble keep it closed
    end
  end

  // parameter writes: only trouble and idle allow the power-off kind
  wire param_limited = (state_q == ST_RUN) || (state_q == ST_QSTOP) ||
                       (state_q == ST_FREACT);
  assign param_refuse_out = param_wr_in && param_limited &&
                            param_needs_off_in;
  assign param_accept_out = param_wr_in && !param_refuse_out;

  // control loop runs in every powered state
  assign ctrl_loop_on_out = !pulse_inh_q;
  assign pulse_inhibit_out = pulse_inh_q;
  assign brake_open_out = brake_open_q;
  assign speed_out = speed;

  // software registers; quick stop request held until enable-operation
  always @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      brake_man_q <= 1'b0;
      qstop_req_q <= 1'b0;
      decel_q <= `DSSE_DECEL_RST;
      irq_mask_q <= {`DSSE_IRQ_W{1'b0}};
    end
    else
    begin
      if (wr_ctrl)
        brake_man_q <= reg_wdata_in[`DSSE_CTRL_BRAKE_MAN];
      if (cmd_enop)
        qstop_req_q <= 1'b0;
      else if (cmd_qstop)
        qstop_req_q <= 1'b1;
      if (reg_wr_in && reg_addr_in == `DSSE_OFS_DECEL)
        decel_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `DSSE_OFS_IRQ_MASK)
        irq_mask_q <= reg_wdata_in[`DSSE_IRQ_W-1:0];
    end
  end

  // sticky events; a read clears, but a new event in that cycle survives
  wire [`DSSE_IRQ_W-1:0] irq_evt;
  assign irq_evt[`DSSE_IRQ_STATE] = (state_d != state_q);
  assign irq_evt[`DSSE_IRQ_MINOR] = (state_d == ST_FREACT) &&
                                    (state_q != ST_FREACT);
  assign irq_evt[`DSSE_IRQ_SERIOUS] = (state_d == ST_TROUBLE) &&
                                      (state_q != ST_TROUBLE);
  assign irq_evt[`DSSE_IRQ_REFUSED] = param_refuse_out;
  wire rd_stat = reg_rd_in && (reg_addr_in == `DSSE_OFS_IRQ_STAT);

  always @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      irq_stat_q <= {`DSSE_IRQ_W{1'b0}};
    else if (rd_stat)
      irq_stat_q <= irq_evt;
    else
      irq_stat_q <= irq_stat_q | irq_evt;
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  // read data stands only in the cycle after the strobe
  always @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rdata_q <= 16'h0000;
    else if (!reg_rd_in)
      rdata_q <= 16'h0000;
    else
    begin
      case (reg_addr_in)
        `DSSE_OFS_STATE_WORD: rdata_q <= sw_q;
        `DSSE_OFS_CTRL: rdata_q <= {12'h000, qstop_req_q, 2'b00, brake_man_q};
        `DSSE_OFS_DECEL: rdata_q <= decel_q;
        `DSSE_OFS_IRQ_STAT: rdata_q <= {12'h000, irq_stat_q};
        `DSSE_OFS_IRQ_MASK: rdata_q <= {12'h000, irq_mask_q};
        `DSSE_OFS_SPEED: rdata_q <= speed;
        default: rdata_q <= 16'h0000; // unmapped reads zero
      endcase
    end
  end

  assign reg_rdata_out = rdata_q;
endmodule

// [dv/dsse_monitor.sv]
/*
  port checker for the drive state encoder.
  assumes it is bound to dsse_top and sees only its ports, one clock.
*/
`timescale 1ns/10ps
module dsse_monitor
(
  input wire mclk_in,
  input wire sys_rst_in,
  input wire reg_rd_in,
  input wire [15:0] reg_rdata_out,
  input wire serious_fault_in,
  input wire param_wr_in,
  input wire param_needs_off_in,
  input wire param_accept_out,
  input wire param_refuse_out,
  input wire brake_open_out,
  input wire pulse_inhibit_out,
  input wire ctrl_loop_on_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  // five samples cover the two sync stages plus the state edge
  chk_fault_off: assert property (
    serious_fault_in [*5] |-> pulse_inhibit_out)
    else $error("power stage on under serious fault");
  chk_fault_brake: assert property (
    serious_fault_in [*5] |-> !brake_open_out)
    else $error("brake open under serious fault");
  chk_param_refuse: assert property (
    param_wr_in && param_needs_off_in && !pulse_inhibit_out
    |-> param_refuse_out && !param_accept_out)
    else $error("write needing power off not refused");
  chk_param_free: assert property (
    param_wr_in && pulse_inhibit_out
    |-> param_accept_out && !param_refuse_out)
    else $error("write refused with power stage off");
  chk_refuse_cause: assert property (
    param_refuse_out |-> param_wr_in && param_needs_off_in)
    else $error("refusal without a cause");
  chk_loop_active: assert property (
    ctrl_loop_on_out != pulse_inhibit_out)
    else $error("control loop disagrees with power stage");
  chk_brake_closed: assert property (
    pulse_inhibit_out |-> !brake_open_out)
    else $error("brake open while power stage off");
  chk_rdata_quiet: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside its cycle");

  cover property (param_refuse_out);
  cover property ($rose(pulse_inhibit_out));
  cover property (brake_open_out);
endmodule

// [dv/dsse_master.sv]
/*
  model of the fieldbus master on the register port.
  assumes one clock; drive commands are plain control writes.
*/
`timescale 1ns/10ps
module dsse_master
(
  input wire mclk_in,
  input wire [15:0] rdata_in,
  output logic [15:0] addr_out = 16'h0000,
  output logic [15:0] wdata_out = 16'h0000,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0
);
  // enable-op and reset-fault reach the device this way
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge mclk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d; // released data must not look still valid
  endtask

  // data is taken in the cycle after the strobe, and only there
  task automatic read(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask
endmodule

// [dv/testbench.sv]
/*
  self-checking bench for dsse_top: commands go through the master
  model, fault pins are driven here. assumes the 4 ns system clock.
*/
`timescale 1ns/10ps
module testbench;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic minor_fault_in = 1'b0;
  logic serious_fault_in = 1'b0;
  logic fault_cause_in = 1'b0;
  logic dcbus_ready_in = 1'b1;
  logic warning_in = 1'b0;
  logic switch_on_in = 1'b1;
  logic [15:0] setpoint_in = 16'h1000;
  logic param_wr_in = 1'b0;
  logic param_needs_off_in = 1'b0;
  wire [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out, speed_out;
  wire reg_wr_in, reg_rd_in, param_accept_out, param_refuse_out;
  wire brake_open_out, pulse_inhibit_out, ctrl_loop_on_out, irq_out;
  logic [15:0] rdv, spd;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;

  always #2 mclk_in = ~mclk_in;

  dsse_top dut
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .minor_fault_in(minor_fault_in),
    .serious_fault_in(serious_fault_in),
    .fault_cause_in(fault_cause_in),
    .dcbus_ready_in(dcbus_ready_in),
    .warning_in(warning_in),
    .switch_on_in(switch_on_in),
    .setpoint_in(setpoint_in),
    .param_wr_in(param_wr_in),
    .param_needs_off_in(param_needs_off_in),
    .param_accept_out(param_accept_out),
    .param_refuse_out(param_refuse_out),
    .brake_open_out(brake_open_out),
    .pulse_inhibit_out(pulse_inhibit_out),
    .ctrl_loop_on_out(ctrl_loop_on_out),
    .speed_out(speed_out),
    .irq_out(irq_out)
  );
  dsse_master mst
  (
    .mclk_in(mclk_in),
    .rdata_in(reg_rdata_out),
    .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in),
    .wr_out(reg_wr_in),
    .rd_out(reg_rd_in)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    mst.read(a, rdv);
    chk(rdv, exp);
  endtask

  task automatic w(input int c);
    repeat (c) @(posedge mclk_in);
  endtask

  // expect {accept, refuse} in the cycle of the attempt
  task automatic prm(input logic nd, input logic [15:0] exp);
    @(posedge mclk_in);
    param_wr_in <= 1'b1;
    param_needs_off_in <= nd;
    #1 chk({14'h0000, param_accept_out, param_refuse_out}, exp);
    @(posedge mclk_in);
    param_wr_in <= 1'b0;
  endtask

  // bounded wait for the power stage to shut off
  task automatic wait_off;
    int n;
    n = 0;
    while (pulse_inhibit_out !== 1'b1 && n < 60)
    begin
      @(posedge mclk_in);
      n++;
    end
    #1 chk({15'h0000, pulse_inhibit_out}, 16'h0001);
  endtask

  task automatic results;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // cut a hang short far beyond the normal run length
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      results();
    end
  end

  initial
  begin
    w(20);
    sys_rst_in <= 1'b0;
    w(4); // let the level pins pass their synchronisers
    rchk(16'h6041, 16'h0070);
    rchk(16'h0010, 16'h0000);
    mst.write(16'h0003, 16'h000f);
    mst.write(16'h0000, 16'h0002);
    rchk(16'h6041, 16'h0037);
    chk({15'h0000, brake_open_out}, 16'h0001);
    chk({15'h0000, ctrl_loop_on_out}, 16'h0001);
    prm(1'b1, 16'h0001);
    prm(1'b0, 16'h0002);
    w(1);
    warning_in <= 1'b1;
    w(4);
    rchk(16'h6041, 16'h00b7);
    w(1);
    warning_in <= 1'b0;
    mst.write(16'h0000, 16'h0008);
    rchk(16'h6041, 16'h0017);
    chk({15'h0000, brake_open_out}, 16'h0000);
    rchk(16'h0000, 16'h0008);
    prm(1'b1, 16'h0001);
    mst.write(16'h0000, 16'h0002);
    rchk(16'h6041, 16'h0037);
    rchk(16'h0004, 16'h1000);
    mst.write(16'h0000, 16'h0001);
    #1 chk({15'h0000, brake_open_out}, 16'h0000);
    mst.write(16'h0000, 16'h0000);
    #1 chk({15'h0000, brake_open_out}, 16'h0001);
    mst.write(16'h0001, 16'h0200);
    rchk(16'h0001, 16'h0200);
    w(20);
    minor_fault_in <= 1'b1;
    w(3);
    rchk(16'h6041, 16'h003f);
    spd = speed_out;
    w(1);
    #1 chk(speed_out, spd - 16'h0200);
    chk({15'h0000, ctrl_loop_on_out}, 16'h0001);
    wait_off();
    rchk(16'h6041, 16'h0038);
    chk({15'h0000, irq_out}, 16'h0001);
    rchk(16'h0002, 16'h000f);
    chk({15'h0000, irq_out}, 16'h0000);
    prm(1'b1, 16'h0002);
    chk({15'h0000, brake_open_out}, 16'h0000);
    chk({15'h0000, ctrl_loop_on_out}, 16'h0000);
    w(1);
    minor_fault_in <= 1'b0;
    fault_cause_in <= 1'b1;
    w(4);
    mst.write(16'h0000, 16'h0004);
    mst.write(16'h0000, 16'h0002);
    rchk(16'h6041, 16'h0038);
    w(1);
    fault_cause_in <= 1'b0;
    w(4);
    mst.write(16'h0000, 16'h0004);
    rchk(16'h6041, 16'h0070);
    mst.write(16'h0003, 16'h0000);
    mst.write(16'h0000, 16'h0002);
    rchk(16'h6041, 16'h0037);
    w(1);
    serious_fault_in <= 1'b1;
    wait_off();
    rchk(16'h6041, 16'h0038);
    chk({15'h0000, irq_out}, 16'h0000);
    mst.write(16'h0003, 16'h000f);
    #1 chk({15'h0000, irq_out}, 16'h0001);
    results();
  end
endmodule

bind dsse_top dsse_monitor mon
(
  .mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .serious_fault_in(serious_fault_in),
  .param_wr_in(param_wr_in),
  .param_needs_off_in(param_needs_off_in),
  .param_accept_out(param_accept_out),
  .param_refuse_out(param_refuse_out),
  .brake_open_out(brake_open_out),
  .pulse_inhibit_out(pulse_inhibit_out),
  .ctrl_loop_on_out(ctrl_loop_on_out)
);
